// >>> common/rdc_pkg.sv
// Package with constants and types for the RS-422 driver enable control block.
package rdc_pkg;
    // System clock rate in Hz.
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned DATA_BITS_MAX = 8;
    localparam logic [3:0] DATA_BITS_RST = 4'h8;
    localparam logic [1:0] STOP_BITS_RST = 2'h1;
    // Number of character intervals of driver lead time before the first bit.
    localparam logic [2:0] LEAD_CHARS = 3'h5;
    localparam int unsigned BAUD_DIV_W = 16;
    // Divider reset value gives 9600 baud at 40 MHz.
    localparam logic [15:0] BAUD_DIV_RST = 16'h1046;
    localparam int unsigned FRAME_BITS_W = 4;
    // Line idle level (marking).
    localparam logic LINE_MARK = 1'b1;
    localparam logic LINE_SPACE = 1'b0;

    typedef enum logic [1:0]
    {
        RDC_IDLE = 2'b00,
        RDC_LEAD = 2'b01,
        RDC_SEND = 2'b11
    } rdc_state_t;
endpackage

// >>> design/rdc_bit_timer.sv
// Baud tick generator used to pace bits and character intervals.
`timescale 1ns/10ps
`default_nettype none
module rdc_bit_timer
(
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [rdc_pkg::BAUD_DIV_W-1:0] baudDiv,
    output logic bitTick
);
    import rdc_pkg::*;

    logic [BAUD_DIV_W-1:0] cnt_r;

    // The count restarts whenever run drops, so the first tick after start is one full bit away.
    always_ff @(posedge clk)
    begin
        if (srst || !run || cnt_r == '0)
            cnt_r <= (baudDiv == '0) ? '0 : baudDiv - 1'b1;
        else
            cnt_r <= cnt_r - 1'b1;
    end

    assign bitTick = run && (cnt_r == '0) && !srst;
endmodule
`default_nettype wire

// >>> design/rs422_driver_enable_ctrl.sv
// RS-422 transmit path with handshake-controlled differential driver enable.
// Operation
// - Handshake on: enable, wait five characters, send, release; the code skips the wait for back-to-back frames.
// - Handshake off: driver enabled permanently.
// - Handshake off only on suitable double-pair links.
// - Single shared pair requires handshake on.
// - Multipoint double-pair slave requires handshake on.
// - A below B marks; A above B spaces; the code drives A (tx_diff_pos) high on mark instead.
`timescale 1ns/10ps
`default_nettype none
module rs422_driver_enable_ctrl
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hw_handshake_mode,
    input wire logic [rdc_pkg::BAUD_DIV_W-1:0] baudDiv,
    input wire logic [3:0] dataBits,
    input wire logic parityEn,
    input wire logic parityOdd,
    input wire logic [1:0] stopBits,
    input wire logic [rdc_pkg::DATA_BITS_MAX-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic tx_diff_pos,
    output logic tx_diff_neg,
    output logic txDriveEn,
    output logic txBusy
);
    import rdc_pkg::*;

    // The block only paces the outgoing line and gates the driver.
    // Framing is set by the configuration inputs, which are expected to stay
    // constant while a character is in flight; changing them mid-frame gives
    // a frame of mixed length.
    // The handshake mode input comes from logic on this clock, so it is not
    // synchronised here.
    // Whether handshake may be off is a property of the network around the
    // port; the logic cannot see the wiring and simply obeys the mode input.

    rdc_state_t state_r;
    logic [DATA_BITS_MAX+3:0] shift_r;
    logic [FRAME_BITS_W-1:0] bitCnt_r;
    logic [2:0] leadCnt_r;
    logic line_r;
    logic drvEn_r;
    logic bitTick;
    logic [FRAME_BITS_W-1:0] frameBits;
    logic parityBit;
    logic [DATA_BITS_MAX+3:0] frameWord;
    logic modeOn_r;

    // Frame length in bits: start, data, optional parity, stop bits.
    assign frameBits = FRAME_BITS_W'(4'h1 + dataBits + {3'h0, parityEn} + {2'h0, stopBits});

    always_comb
    begin
        parityBit = parityOdd;
        for (int i = 0; i < DATA_BITS_MAX; i++)
        begin
            if (i < dataBits)
                parityBit = parityBit ^ txData[i];
        end
    end

    // Frame assembled LSB first behind a space start bit; upper bits mark and give the stop bits.
    always_comb
    begin
        frameWord = {(DATA_BITS_MAX+4){LINE_MARK}};
        frameWord[0] = LINE_SPACE;
        for (int i = 0; i < DATA_BITS_MAX; i++)
        begin
            if (i < dataBits)
                frameWord[i+1] = txData[i];
        end
        if (parityEn)
            frameWord[dataBits+1] = parityBit;
    end

    // One timer paces both the lead wait and the data bits.
    // Counting the lead in bit ticks keeps the wait an exact whole number of
    // frames at any divider, at the cost of sharing the counter between the
    // two phases.
    rdc_bit_timer u_timer
    (
        .clk(clk),
        .srst(srst),
        .run(state_r != RDC_IDLE),
        .baudDiv(baudDiv),
        .bitTick(bitTick)
    );

    assign txReady = (state_r == RDC_IDLE) && !srst;
    assign txBusy = (state_r != RDC_IDLE);

    // Mode for the release is only sampled while idle so a frame in flight is never cut short.
    always_ff @(posedge clk)
    begin
        if (srst)
            modeOn_r <= 1'b1;
        else if (state_r == RDC_IDLE)
            modeOn_r <= hw_handshake_mode;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= RDC_IDLE;
            leadCnt_r <= '0;
            bitCnt_r <= '0;
            shift_r <= '1;
        end
        else
        begin
            unique case (state_r)
                RDC_IDLE:
                begin
                    if (txValid)
                    begin
                        shift_r <= frameWord;
                        bitCnt_r <= '0;
                        leadCnt_r <= '0;
                        // Lead time is only needed when the driver was released.
                        state_r <= (hw_handshake_mode && !drvEn_r) ? RDC_LEAD : RDC_SEND;
                    end
                end
                // The line stays marking during the lead so that receivers
                // on the pair see a settled idle state before the start bit.
                RDC_LEAD:
                begin
                    if (bitTick)
                    begin
                        if (bitCnt_r == frameBits - 1'b1)
                        begin
                            bitCnt_r <= '0;
                            if (leadCnt_r == LEAD_CHARS - 1'b1)
                                state_r <= RDC_SEND;
                            else
                                leadCnt_r <= leadCnt_r + 1'b1;
                        end
                        else
                            bitCnt_r <= bitCnt_r + 1'b1;
                    end
                end
                RDC_SEND:
                begin
                    if (bitTick)
                    begin
                        shift_r <= {LINE_MARK, shift_r[DATA_BITS_MAX+3:1]};
                        if (bitCnt_r == frameBits - 1'b1)
                            state_r <= RDC_IDLE;
                        else
                            bitCnt_r <= bitCnt_r + 1'b1;
                    end
                end
                default:
                    state_r <= RDC_IDLE;
            endcase
        end
    end

    // Line level: marking while idle or leading in, frame bits while sending.
    always_ff @(posedge clk)
    begin
        if (srst)
            line_r <= LINE_MARK;
        else if (state_r == RDC_SEND)
            line_r <= shift_r[0];
        else
            line_r <= LINE_MARK;
    end

    // Driver enable: held on without handshake, bracketing each frame with it.
    // Back-to-back frames keep the driver on, so the lead wait only precedes a burst.
    always_ff @(posedge clk)
    begin
        if (srst)
            drvEn_r <= 1'b0;
        else if (!hw_handshake_mode)
            drvEn_r <= 1'b1;
        else if (state_r == RDC_IDLE && txValid)
            drvEn_r <= 1'b1;
        else if (state_r == RDC_IDLE && modeOn_r)
            drvEn_r <= 1'b0;
    end

    // A request in the same idle cycle as the release wins, so the driver
    // never drops for a single cycle between two frames of one burst.
    // The enable comes straight from a flip-flop, so the pin never glitches.
    assign txDriveEn = drvEn_r;
    // Differential pair: mark drives A high and B low.
    assign tx_diff_pos = line_r;
    assign tx_diff_neg = ~line_r;
endmodule
`default_nettype wire

// >>> verif/rdc_monitor.sv
// Checker for driver enable and line state of the transmit block.
`timescale 1ns/10ps
`default_nettype none
module rdc_monitor
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hw_handshake_mode,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic tx_diff_pos,
    input wire logic tx_diff_neg,
    input wire logic txDriveEn,
    input wire logic txBusy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_pair_opposite: assert property (tx_diff_neg == !tx_diff_pos) else $error("pair not opposite");
    a_idle_mark: assert property (!txBusy && $past(!txBusy) |-> tx_diff_pos) else $error("idle not mark");
    a_lead_mark: assert property ($rose(txDriveEn) && hw_handshake_mode |-> tx_diff_pos [*8])
        else $error("lead not mark");
    a_space_driven: assert property (!tx_diff_pos |-> txDriveEn) else $error("space undriven");
    a_always_on: assert property (!hw_handshake_mode && $past(!hw_handshake_mode) |=> txDriveEn)
        else $error("driver off");
    a_take_busy: assert property (txReady && txValid |=> txBusy) else $error("request lost");
    a_release_drv: assert property (hw_handshake_mode && $fell(txBusy) && !txValid |-> ##[1:2] !txDriveEn)
        else $error("driver kept");
    a_ready_idle: assert property (txReady == !txBusy) else $error("ready wrong");
endmodule
bind rs422_driver_enable_ctrl rdc_monitor mon (.clk(clk), .srst(srst), .hw_handshake_mode(hw_handshake_mode),
    .txValid(txValid), .txReady(txReady), .tx_diff_pos(tx_diff_pos), .tx_diff_neg(tx_diff_neg),
    .txDriveEn(txDriveEn), .txBusy(txBusy));
`default_nettype wire

// >>> verif/rdc_far_node.sv
// Far serial node that decodes eight data bits from the pair.
`timescale 1ns/10ps
`default_nettype none
module rdc_far_node #(parameter int DIV = 2)
(
    input wire logic clk,
    input wire logic lineA,
    input wire logic lineB,
    input wire logic driveEn,
    output logic [7:0] rxByte,
    output logic rxDone
);
    logic mark;
    int cnt = 0;
    int idx = -1;
    // Termination biases a released pair to marking, so no driver means idle.
    assign mark = driveEn ? (lineA && !lineB) : 1'b1;
    always @(posedge clk)
    begin
        rxDone <= 1'b0;
        if (idx < 0)
        begin
            if (!mark)
            begin
                idx = 0;
                cnt = 2 * DIV - 1;
            end
        end
        else if (idx == 8)
            idx = mark ? -1 : 8;
        else if (--cnt == 0)
        begin
            rxByte[idx] <= mark;
            idx++;
            cnt = DIV;
            rxDone <= (idx == 8);
        end
    end
endmodule
`default_nettype wire

// >>> verif/rs422_driver_enable_ctrl_bench.sv
// Testbench for the transmit block with gated and ungated driver.
`timescale 1ns/10ps
`default_nettype none
module rs422_driver_enable_ctrl_bench;
    import rdc_pkg::*;
    logic clk, srst, hwMode, parityEn, txValid, txReady, pos, neg, drv, busy, rxDone;
    logic [1:0] stopBits;
    logic [7:0] txData, rxByte;
    int failCount = 0;
    int samplesChecked = 0;
    int k;
    rs422_driver_enable_ctrl uut (.clk(clk), .srst(srst), .hw_handshake_mode(hwMode), .baudDiv(16'h0002),
        .dataBits(4'h8), .parityEn(parityEn), .parityOdd(1'b1), .stopBits(stopBits), .txData(txData),
        .txValid(txValid), .txReady(txReady), .tx_diff_pos(pos), .tx_diff_neg(neg), .txDriveEn(drv), .txBusy(busy));
    rdc_far_node #(.DIV(2)) far (.clk(clk), .lineA(pos), .lineB(neg), .driveEn(drv), .rxByte(rxByte), .rxDone(rxDone));
    task automatic results();
        $display("checked=%0d errors=%0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            failCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Counts negedges from the take until the start bit shows, then waits for the far node.
    task automatic send(input logic [7:0] d, output int lead);
        int n;
        n = 0;
        lead = 0;
        txData = d;
        txValid = 1'b1;
        @(negedge clk);
        txValid = 1'b0;
        while (!rxDone && n < 900)
        begin
            @(negedge clk);
            n++;
            if (lead == 0 && !pos)
                lead = n;
        end
        if (n >= 900)
        begin
            failCount++;
            results();
        end
        check(rxByte, d);
    endtask
    task automatic t_always_on(input logic [7:0] d);
        send(d, k);
        check(k <= 3, 1);
        repeat (20) @(negedge clk);
        check(drv, 1);
    endtask
    // Lead is five full frames of 2 clocks per bit beyond the ungated start delay.
    task automatic t_gated(input logic par, input logic [1:0] st, input logic [7:0] d);
        int lead;
        int n;
        n = 0;
        parityEn = par;
        stopBits = st;
        send(d, lead);
        check(32'(lead - k), 32'(5 * (9 + par + st) * 2));
        while (drv && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        check({drv, pos}, 2'b01);
    endtask
    // Reset in the middle of a lead wait must release the driver and park the line.
    task automatic t_reset();
        txData = 8'h5a;
        txValid = 1'b1;
        @(negedge clk);
        txValid = 1'b0;
        repeat (10) @(negedge clk);
        check(busy, 1);
        check(drv, 1);
        srst = 1'b1;
        @(negedge clk);
        check({pos, neg, drv, txReady}, 4'h8);
        @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        check({drv, busy, txReady}, 3'h1);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        srst = 1'b1;
        hwMode = 1'b0;
        parityEn = 1'b0;
        stopBits = 2'h1;
        txData = 8'h00;
        txValid = 1'b0;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        t_always_on(8'ha5);
        hwMode = 1'b1;
        repeat (3) @(negedge clk);
        t_gated(1'b0, 2'h1, 8'h3c);
        t_gated(1'b1, 2'h2, 8'h81);
        t_reset();
        t_gated(1'b0, 2'h1, 8'hc3);
        results();
    end
endmodule
`default_nettype wire
